/* rtl/ccisj_pkg.sv */
package ccisj_pkg;

  // Operation codes presented by the decode stage.
  typedef enum logic [2:0] {
    CCISJ_OP_NONE                = 3'h0,
    CCISJ_OP_CLEAR_FILE_REG      = 3'h1,
    CCISJ_OP_CLEAR_ACCUMULATOR   = 3'h2,
    CCISJ_OP_DECREMENT_REG       = 3'h3,
    CCISJ_OP_DECREMENT_SKIP_NULL = 3'h4,
    CCISJ_OP_INCREMENT_SKIP_NULL = 3'h5,
    CCISJ_OP_JUMP_ABSOLUTE       = 3'h6
  } ccisj_op_t;

  // Execute states, one-hot.
  typedef enum logic [1:0] {
    CCISJ_ST_EXEC  = 2'h1,
    CCISJ_ST_FLUSH = 2'h2
  } ccisj_state_t;

  localparam int          CCISJ_DATA_W      = 8;
  localparam int          CCISJ_ADDR_W      = 7;
  localparam int          CCISJ_PC_W        = 15;
  localparam int          CCISJ_JUMP_W      = 11;
  localparam int          CCISJ_LATCH_LO    = 3;
  localparam int          CCISJ_LATCH_HI    = 6;
  localparam logic [7:0]  CCISJ_ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  CCISJ_ONE_BYTE    = 8'h01;
  localparam logic [6:0]  CCISJ_ADDR_RESET  = 7'h00;
  localparam logic [14:0] CCISJ_PC_RESET    = 15'h0000;

endpackage

/* rtl/ccisj_exec.sv */
`timescale 1ns/10ps
// What this block does
// - Clear file register: write zero to addressed register, set zero flag only.
// - Clear accumulator: no operand, load zero into accumulator, set zero flag.
// - Decrement: result to accumulator if destination 0, else file register; zero flag.
// - Decrement-skip: decrement to destination, no flags; zero result skips next (two cycles).
// - Increment-skip: increment to destination, no flags; zero result skips next (two cycles).
// - Nonzero skip result continues with the next instruction, no extra cycle.
// - Jump copies its 11-bit operand into program counter bits 10 to 0.
// - Jump fills program counter bits 14 to 11 from page latch bits 6 to 3.
// - Jump always takes two cycles and leaves every status flag unchanged.
module ccisj_exec
  import ccisj_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      instr_valid,
  input  wire logic [2:0]                instr_op,
  input  wire logic [CCISJ_ADDR_W-1:0]   file_addr,
  input  wire logic                      dest_sel,
  input  wire logic [CCISJ_JUMP_W-1:0]   jump_target,
  input  wire logic [CCISJ_DATA_W-1:0]   file_rdata,
  input  wire logic [CCISJ_DATA_W-1:0]   jump_page_latch,
  output logic                           file_we,
  output logic [CCISJ_ADDR_W-1:0]        file_waddr,
  output logic [CCISJ_DATA_W-1:0]        file_wdata,
  output logic                           acc_we,
  output logic [CCISJ_DATA_W-1:0]        acc_wdata,
  output logic                           zero_we,
  output logic                           zero_flag,
  output logic                           pc_load,
  output logic [CCISJ_PC_W-1:0]          pc_target,
  output logic                           flush_busy
);

  ccisj_state_t             state;
  ccisj_op_t                op;
  logic [CCISJ_DATA_W-1:0]  dec_val;
  logic [CCISJ_DATA_W-1:0]  inc_val;
  logic                     live;
  logic                     skip_now;

  // Timing overview. An instruction is taken at the rising edge at which
  // instr_valid is high and no flush is in progress. Every effect appears as a
  // registered strobe one cycle later: file_we, acc_we, zero_we or pc_load,
  // each high for exactly one cycle. The cycle that follows a taken jump, or a
  // skip whose result is zero, raises flush_busy and ignores whatever the
  // decode stage presents. Reset clears every strobe and leaves the block
  // ready to take an instruction at the first edge after release.
  // Data outputs can change between writes (file_waddr follows file_addr every cycle), so a consumer must
  // look at them only while the matching strobe is high.

  // True when an 8-bit result is zero; shared by the skip test and the zero flag.
  function automatic logic is_null_byte(input logic [CCISJ_DATA_W-1:0] value);
    return (value == CCISJ_ZERO_BYTE);
  endfunction

  // Builds the fifteen-bit jump destination from the page latch and the operand.
  function automatic logic [CCISJ_PC_W-1:0] jump_dest(
    input logic [CCISJ_DATA_W-1:0] page,
    input logic [CCISJ_JUMP_W-1:0] target
  );
    return {page[CCISJ_LATCH_HI:CCISJ_LATCH_LO], target};
  endfunction

  // Decode only in the execute state; a flushed slot must see no operation.
  // The decode stage keeps presenting words while the fetched successor of a
  // skip or jump is thrown away, so the valid bit alone cannot be trusted.
  // Codes 0 and 7 fall through every case below as a plain no-operation.
  // The adder and subtractor wrap at eight bits, which is what makes an
  // increment of all ones or a decrement of one land on zero.
  assign op       = ccisj_op_t'(instr_op);
  assign live     = instr_valid && (state == CCISJ_ST_EXEC);
  assign dec_val  = file_rdata - CCISJ_ONE_BYTE;
  assign inc_val  = file_rdata + CCISJ_ONE_BYTE;

  // Skip is taken only on a zero result; a nonzero result keeps the pipe flowing.
  // The decision uses the file word read in this same cycle, so the register
  // file must deliver file_rdata combinationally from file_addr.
  // A jump always costs the second cycle, whatever its target.
  always_comb begin
    skip_now = 1'b0;
    if (live) begin
      unique case (op)
        CCISJ_OP_DECREMENT_SKIP_NULL: skip_now = is_null_byte(dec_val);
        CCISJ_OP_INCREMENT_SKIP_NULL: skip_now = is_null_byte(inc_val);
        CCISJ_OP_JUMP_ABSOLUTE:       skip_now = 1'b1;
        default:                      skip_now = 1'b0;
      endcase
    end
  end

  // Second cycle of a skip or jump discards the already fetched word.
  // flush_busy mirrors the flush state one for one, so the core can hold its
  // fetch stage from a register rather than from decode logic.
  // Two taken skips cannot follow back to back: the word after a zero-result skip or a jump is never taken.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= CCISJ_ST_EXEC;
      flush_busy <= 1'b0;
    end else begin
      unique case (state)
        CCISJ_ST_EXEC: begin
          if (skip_now) begin
            state      <= CCISJ_ST_FLUSH;
            flush_busy <= 1'b1;
          end else begin
            flush_busy <= 1'b0;
          end
        end
        CCISJ_ST_FLUSH: begin
          state      <= CCISJ_ST_EXEC;
          flush_busy <= 1'b0;
        end
        default: begin
          state      <= CCISJ_ST_EXEC;
          flush_busy <= 1'b0;
        end
      endcase
    end
  end

  // Data file and accumulator writes; the address is 7 bits by its port width.
  // The write address follows file_addr every cycle, which saves a mux; the
  // strobes alone decide whether anything is written.
  // Both data words are loaded for a destination-select op so the strobe that
  // fires always finds its value ready; the other word is simply not used.
  // Write data holds its value until an op loads it, whether or not its strobe fires.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      file_we    <= 1'b0;
      file_waddr <= CCISJ_ADDR_RESET;
      file_wdata <= CCISJ_ZERO_BYTE;
      acc_we     <= 1'b0;
      acc_wdata  <= CCISJ_ZERO_BYTE;
    end else begin
      file_we    <= 1'b0;
      acc_we     <= 1'b0;
      file_waddr <= file_addr;
      if (live) begin
        unique case (op)
          CCISJ_OP_CLEAR_FILE_REG: begin
            file_we    <= 1'b1;
            file_wdata <= CCISJ_ZERO_BYTE;
          end
          CCISJ_OP_CLEAR_ACCUMULATOR: begin
            acc_we    <= 1'b1;
            acc_wdata <= CCISJ_ZERO_BYTE;
          end
          CCISJ_OP_DECREMENT_REG,
          CCISJ_OP_DECREMENT_SKIP_NULL: begin
            file_we    <= dest_sel;
            acc_we     <= !dest_sel;
            file_wdata <= dec_val;
            acc_wdata  <= dec_val;
          end
          CCISJ_OP_INCREMENT_SKIP_NULL: begin
            file_we    <= dest_sel;
            acc_we     <= !dest_sel;
            file_wdata <= inc_val;
            acc_wdata  <= inc_val;
          end
          default: begin
            file_we <= 1'b0;
          end
        endcase
      end
    end
  end

  // Only the two clears and the plain decrement touch the zero flag.
  // The skip forms and the jump leave status alone, so their slots keep
  // zero_we low and zero_flag at its old value.
  // zero_flag is only meaningful in the cycle in which zero_we is high.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_we   <= 1'b0;
      zero_flag <= 1'b0;
    end else begin
      zero_we <= 1'b0;
      if (live) begin
        unique case (op)
          CCISJ_OP_CLEAR_FILE_REG,
          CCISJ_OP_CLEAR_ACCUMULATOR: begin
            zero_we   <= 1'b1;
            zero_flag <= 1'b1;
          end
          CCISJ_OP_DECREMENT_REG: begin
            zero_we   <= 1'b1;
            zero_flag <= is_null_byte(dec_val);
          end
          default: begin
            zero_we <= 1'b0;
          end
        endcase
      end
    end
  end

  // Jump target: page bits come from latch bits 6 to 3, not just 4 to 3.
  // The latch is sampled in the taking cycle, so a latch update in that same
  // cycle is not seen by the jump; software must write the latch beforehand.
  // pc_target holds the last jump destination until the next jump.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_load   <= 1'b0;
      pc_target <= CCISJ_PC_RESET;
    end else begin
      pc_load <= 1'b0;
      if (live && op == CCISJ_OP_JUMP_ABSOLUTE) begin
        pc_load   <= 1'b1;
        pc_target <= jump_dest(jump_page_latch, jump_target);
      end
    end
  end

endmodule // ccisj_exec

/* test/ccisj_exec_sva.sv */
`timescale 1ns/10ps
module ccisj_exec_sva (
  input logic        sys_clk,
  input logic        arst_n,
  input logic        instr_valid,
  input logic [2:0]  instr_op,
  input logic        dest_sel,
  input logic [10:0] jump_target,
  input logic [7:0]  file_rdata,
  input logic        file_we,
  input logic        acc_we,
  input logic [7:0]  acc_wdata,
  input logic        zero_we,
  input logic        zero_flag,
  input logic        pc_load,
  input logic [14:0] pc_target,
  input logic        flush_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Nothing is taken in the flushed slot, so every antecedent except that of p_nop excludes it.
  wire tk = instr_valid && !flush_busy;
  property p_clf; tk && instr_op == 3'h1 |=> file_we && zero_we && zero_flag; endproperty
  property p_clw; tk && instr_op == 3'h2 |=> acc_we && acc_wdata == 8'h00 && zero_flag; endproperty
  property p_dec; tk && instr_op == 3'h3 && !dest_sel |=>
    acc_we && !file_we && acc_wdata == $past(file_rdata) - 8'h01; endproperty
  property p_nfl; tk && instr_op inside {3'h4, 3'h5} |=> !zero_we; endproperty
  property p_skp; tk && instr_op == 3'h5 && file_rdata == 8'hFF |=> flush_busy; endproperty
  property p_nsk; tk && instr_op == 3'h4 && file_rdata != 8'h01 |=> !flush_busy; endproperty
  property p_jmp; tk && instr_op == 3'h6 |=>
    pc_load && flush_busy && !zero_we && pc_target[10:0] == $past(jump_target); endproperty
  property p_nop; flush_busy |=> !file_we && !acc_we && !zero_we && !pc_load; endproperty
  a_clf: assert property (p_clf) else $error("clear file");
  a_clw: assert property (p_clw) else $error("clear acc");
  a_dec: assert property (p_dec) else $error("decrement");
  a_nfl: assert property (p_nfl) else $error("skip flag");
  a_skp: assert property (p_skp) else $error("inc skip");
  a_nsk: assert property (p_nsk) else $error("no skip");
  a_jmp: assert property (p_jmp) else $error("jump");
  a_nop: assert property (p_nop) else $error("flush slot");
  c_jmp: cover property (tk && instr_op == 3'h6);
  c_dsk: cover property (tk && instr_op == 3'h4 ##1 flush_busy);
  c_isk: cover property (tk && instr_op == 3'h5 ##1 !flush_busy);
endmodule // ccisj_exec_sva
bind ccisj_exec ccisj_exec_sva i_sva (
  .sys_clk     (sys_clk),
  .arst_n      (arst_n),
  .instr_valid (instr_valid),
  .instr_op    (instr_op),
  .dest_sel    (dest_sel),
  .jump_target (jump_target),
  .file_rdata  (file_rdata),
  .file_we     (file_we),
  .acc_we      (acc_we),
  .acc_wdata   (acc_wdata),
  .zero_we     (zero_we),
  .zero_flag   (zero_flag),
  .pc_load     (pc_load),
  .pc_target   (pc_target),
  .flush_busy  (flush_busy)
);

/* test/tb_ccisj_exec.sv */
`timescale 1ns/10ps
module tb_ccisj_exec;
  import ccisj_pkg::*;
  logic        sys_clk = 0, arst_n = 0, instr_valid = 0, dest_sel = 0, fwe, awe, zwe, pl, fl, tk;
  logic [2:0]  instr_op = 0;
  logic [6:0]  file_addr = 0, wa;
  logic [10:0] jump_target = 0;
  logic [7:0]  file_rdata = 0, jump_page_latch = 0, fwd, awd, res;
  logic [14:0] pt;
  logic [31:0] rn;
  wire         file_we, acc_we, zero_we, zero_flag, pc_load, flush_busy;
  wire  [6:0]  file_waddr;
  wire  [7:0]  file_wdata, acc_wdata;
  wire  [14:0] pc_target;
  int          n_mismatch = 0, num_checks = 0, seed = 32'hE32A09BE;
  ccisj_exec i_dut (
    .sys_clk         (sys_clk),
    .arst_n          (arst_n),
    .instr_valid     (instr_valid),
    .instr_op        (instr_op),
    .file_addr       (file_addr),
    .dest_sel        (dest_sel),
    .jump_target     (jump_target),
    .file_rdata      (file_rdata),
    .jump_page_latch (jump_page_latch),
    .file_we         (file_we),
    .file_waddr      (file_waddr),
    .file_wdata      (file_wdata),
    .acc_we          (acc_we),
    .acc_wdata       (acc_wdata),
    .zero_we         (zero_we),
    .zero_flag       (zero_flag),
    .pc_load         (pc_load),
    .pc_target       (pc_target),
    .flush_busy      (flush_busy)
  );
  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Random traffic biased to the skip boundaries, so flushed slots are hit often.
  initial begin
    fl = 0;
    repeat (6) @(negedge sys_clk);
    arst_n = 1;
    repeat (3000) begin
      rn = $random(seed);
      {instr_op, dest_sel, file_addr, jump_target} = rn[21:0];
      file_rdata = rn[23:22] == 0 ? 8'h01 : rn[23:22] == 1 ? 8'hFF : rn[31:24];
      rn = $random(seed);
      {instr_valid, jump_page_latch} = {rn[10:8] != 0, rn[7:0]};
      tk = instr_valid && !fl;
      res = instr_op == 3'h5 ? file_rdata + 8'h01 : file_rdata - 8'h01;
      {fwe, awe, zwe, pl, wa, fwd, awd} = {4'h0, file_addr, 16'h0000};
      pt = {jump_page_latch[6:3], jump_target};
      if (tk && instr_op inside {3'h1, 3'h2}) {fwe, awe, zwe} = {instr_op[0], instr_op[1], 1'b1};
      if (tk && instr_op inside {[3'h3:3'h5]})
        {fwe, awe, zwe, fwd, awd} = {dest_sel, !dest_sel, instr_op == 3'h3, res, res};
      pl = tk && instr_op == 3'h6;
      fl = pl || (tk && instr_op inside {3'h4, 3'h5} && res == 8'h00);
      @(negedge sys_clk);
      chk(flush_busy, fl);
      chk({file_we, acc_we, zero_we, pc_load}, {fwe, awe, zwe, pl});
      if (fwe) chk({file_waddr, file_wdata}, {wa, fwd});
      if (awe) chk(acc_wdata, awd);
      if (zwe) chk(zero_flag, instr_op != 3'h3 || res == 8'h00);
      if (pl) chk(pc_target, pt);
    end
    close_out;
  end
endmodule // tb_ccisj_exec
